// *** pcfs_pkg.sv ***
// package: offsets, reset values and timing for the power correction,
// fault recovery and status register slice
// assumes byte-wide register port from the control interface decoder
package pcfs_pkg;
    localparam logic [7:0] ADDR_PWR_HI = 8'h27;
    localparam logic [7:0] ADDR_PWR_LO = 8'h28;
    localparam logic [7:0] ADDR_DIST_HI = 8'h29;
    localparam logic [7:0] ADDR_DIST_LO = 8'h2a;
    localparam logic [7:0] ADDR_FRD_HI = 8'h2b;
    localparam logic [7:0] ADDR_FRD_LO = 8'h2c;
    localparam logic [7:0] ADDR_STATUS = 8'h2d;
    localparam logic [7:0] RST_PWR_HI = 8'h1a;
    localparam logic [7:0] RST_PWR_LO = 8'hc0;
    localparam logic [7:0] RST_DIST_HI = 8'hf3;
    localparam logic [7:0] RST_DIST_LO = 8'h33;
    localparam logic [7:0] RST_FRD_HI = 8'h00;
    localparam logic [7:0] RST_FRD_LO = 8'h0c;
    // status bit positions
    localparam int STAT_PLL_UNLOCK = 7;
    localparam int STAT_FAULT = 6;
    localparam int STAT_UV = 5;
    localparam int STAT_RSVD = 4;
    localparam int STAT_OC_FAULT = 3;
    localparam int STAT_OC_WARN = 2;
    localparam int STAT_T_FAULT = 1;
    localparam int STAT_T_WARN = 0;
    // one unit of recovery delay, in ns, and its cycle count at 125 MHz
    localparam int CLK_PERIOD_NS = 8;
    localparam int FRD_UNIT_NS = 83000;
    localparam int FRD_UNIT_CYC = FRD_UNIT_NS / CLK_PERIOD_NS;
    localparam int FRD_UNIT_W = 14;
endpackage

// *** pcfs_recovery_timer.sv ***
// fault recovery hold-low timer
// assumes fault_n synchronous to clk, delay value stable during a hold
`timescale 1ns/1ps
module pcfs_recovery_timer
    import pcfs_pkg::*;
#(
    parameter int UNIT_CYC = FRD_UNIT_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // control
    input wire logic fault_n,
    input wire logic [15:0] delay_units,
    // output
    output logic hiz_ctrl
);
    logic [FRD_UNIT_W-1:0] pre;
    logic [15:0] units;
    logic hold;
    logic [FRD_UNIT_W-1:0] next_pre;
    logic [15:0] next_units;
    logic next_hold;
    logic next_hiz;
    localparam logic [FRD_UNIT_W-1:0] PRE_LAST = FRD_UNIT_W'(UNIT_CYC - 1);

    always_comb begin
        next_pre = pre;
        next_units = units;
        next_hold = hold;
        if (!fault_n) begin
            // fault retriggers the whole delay while it stands
            next_hold = 1'b1;
            next_pre = '0;
            next_units = delay_units;
        end else if (hold) begin
            if (pre == PRE_LAST) begin
                next_pre = '0;
                // a zero value is reserved; treated as one unit
                if (units <= 16'h0001) begin
                    next_hold = 1'b0;
                end else begin
                    next_units = units - 16'h0001;
                end
            end else begin
                next_pre = pre + 1'b1;
            end
        end
        next_hiz = !(next_hold);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pre <= '0;
            units <= '0;
            hold <= 1'b0;
            hiz_ctrl <= 1'b1;
        end else begin
            pre <= next_pre;
            units <= next_units;
            hold <= next_hold;
            hiz_ctrl <= next_hiz;
        end
    end

    property p_fault_low;
        @(posedge clk) disable iff (!rst_b)
        !fault_n |=> !hiz_ctrl;
    endproperty
    a_fault_low: assert property (p_fault_low) else $error("hiz high");

    property p_hold_min;
        @(posedge clk) disable iff (!rst_b)
        $rose(fault_n) |-> !hiz_ctrl [*8];
    endproperty
    a_hold_min: assert property (p_hold_min) else $error("hold short");
endmodule

// *** pcfs_regs.sv ***
// power correction, distortion compensation, fault recovery and status
// registers; byte-wide port from the control interface decoder
// assumes wr/rd strobes are one-cycle pulses synchronous to clk
//
// Operation
// - power override value used when select is set
// - distortion override value used when select set
// - fault drives hiz control low, holds delay
// - each delay unit about 0.083 ms
// - recovery delay resets to 0x000C
// - status byte read-only, live, writes ignored
// - bridge status flags one normal, zero on fault; pll unlock bit one when unlocked
// - status bit layout pll unlock down to warn
`timescale 1ns/1ps
module pcfs_regs
    import pcfs_pkg::*;
#(
    parameter int UNIT_CYC = FRD_UNIT_CYC,
    parameter logic [15:0] DEF_PWR = 16'h0000,
    parameter logic [15:0] DEF_DIST = 16'h0000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // override selects from the configuration registers
    input wire logic max_power_override_sel,
    input wire logic distortion_override_sel,
    // power bridge and pll status; bridge flags active low, pll_unlocked_flag active high
    input wire logic pll_unlocked_flag,
    input wire logic fault_n,
    input wire logic undervoltage_flag_n,
    input wire logic overcurrent_fault_n,
    input wire logic overcurrent_warn_n,
    input wire logic thermal_fault_n,
    input wire logic thermal_warn_n,
    // coefficients to the datapath
    output logic [15:0] max_power_correction,
    output logic [15:0] distortion_comp_coef,
    // power stage
    output logic bridge_hiz_ctrl
);
    logic [7:0] pwr_hi, pwr_lo, dist_hi, dist_lo, frd_hi, frd_lo;
    logic [7:0] next_pwr_hi, next_pwr_lo, next_dist_hi, next_dist_lo;
    logic [7:0] next_frd_hi, next_frd_lo;
    logic [7:0] status_live;
    logic [7:0] next_rdata;
    logic [15:0] next_pwr_out, next_dist_out;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
        hit = reg_wr && (a == t);
    endfunction

    always_comb begin
        status_live = '0;
        status_live[STAT_PLL_UNLOCK] = pll_unlocked_flag;
        status_live[STAT_FAULT] = fault_n;
        status_live[STAT_UV] = undervoltage_flag_n;
        status_live[STAT_RSVD] = 1'b0;
        status_live[STAT_OC_FAULT] = overcurrent_fault_n;
        status_live[STAT_OC_WARN] = overcurrent_warn_n;
        status_live[STAT_T_FAULT] = thermal_fault_n;
        status_live[STAT_T_WARN] = thermal_warn_n;
    end

    always_comb begin
        next_pwr_hi = hit(reg_addr, ADDR_PWR_HI) ? reg_wdata : pwr_hi;
        next_pwr_lo = hit(reg_addr, ADDR_PWR_LO) ? reg_wdata : pwr_lo;
        next_dist_hi = hit(reg_addr, ADDR_DIST_HI) ? reg_wdata : dist_hi;
        next_dist_lo = hit(reg_addr, ADDR_DIST_LO) ? reg_wdata : dist_lo;
        next_frd_hi = hit(reg_addr, ADDR_FRD_HI) ? reg_wdata : frd_hi;
        next_frd_lo = hit(reg_addr, ADDR_FRD_LO) ? reg_wdata : frd_lo;
        // status address has no write path
        next_pwr_out = max_power_override_sel ?
            {pwr_hi, pwr_lo} : DEF_PWR;
        next_dist_out = distortion_override_sel ?
            {dist_hi, dist_lo} : DEF_DIST;
        case (reg_addr)
            ADDR_PWR_HI: next_rdata = pwr_hi;
            ADDR_PWR_LO: next_rdata = pwr_lo;
            ADDR_DIST_HI: next_rdata = dist_hi;
            ADDR_DIST_LO: next_rdata = dist_lo;
            ADDR_FRD_HI: next_rdata = frd_hi;
            ADDR_FRD_LO: next_rdata = frd_lo;
            ADDR_STATUS: next_rdata = status_live;
            default: next_rdata = 8'h00;
        endcase
        if (!reg_rd) begin
            next_rdata = reg_rdata;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pwr_hi <= RST_PWR_HI;
            pwr_lo <= RST_PWR_LO;
            dist_hi <= RST_DIST_HI;
            dist_lo <= RST_DIST_LO;
            frd_hi <= RST_FRD_HI;
            frd_lo <= RST_FRD_LO;
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
            max_power_correction <= 16'h0000;
            distortion_comp_coef <= 16'h0000;
        end else begin
            pwr_hi <= next_pwr_hi;
            pwr_lo <= next_pwr_lo;
            dist_hi <= next_dist_hi;
            dist_lo <= next_dist_lo;
            frd_hi <= next_frd_hi;
            frd_lo <= next_frd_lo;
            reg_rdata <= next_rdata;
            reg_rvalid <= reg_rd;
            max_power_correction <= next_pwr_out;
            distortion_comp_coef <= next_dist_out;
        end
    end

    // zero delay is not blocked here; the timer treats it as one unit
    pcfs_recovery_timer #(
        .UNIT_CYC(UNIT_CYC)
    ) u_timer (
        .clk(clk),
        .rst_b(rst_b),
        .fault_n(fault_n),
        .delay_units({frd_hi, frd_lo}),
        .hiz_ctrl(bridge_hiz_ctrl)
    );

    property p_pwr_sel;
        @(posedge clk) disable iff (!rst_b)
        max_power_override_sel |=>
            max_power_correction == $past({pwr_hi, pwr_lo});
    endproperty
    a_pwr_sel: assert property (p_pwr_sel) else $error("power sel");

    property p_pwr_dflt;
        @(posedge clk) disable iff (!rst_b)
        !max_power_override_sel |=> max_power_correction == DEF_PWR;
    endproperty
    a_pwr_dflt: assert property (p_pwr_dflt) else $error("pwr dflt");

    property p_pwr_hi_wr;
        @(posedge clk) disable iff (!rst_b)
        reg_wr && reg_addr == ADDR_PWR_HI |=> pwr_hi == $past(reg_wdata);
    endproperty
    a_pwr_hi_wr: assert property (p_pwr_hi_wr) else $error("pwr hi");

    property p_dist_sel;
        @(posedge clk) disable iff (!rst_b)
        !distortion_override_sel |=> distortion_comp_coef == DEF_DIST;
    endproperty
    a_dist_sel: assert property (p_dist_sel) else $error("dist dflt");

    property p_dist_ovr;
        @(posedge clk) disable iff (!rst_b)
        distortion_override_sel |=>
            distortion_comp_coef == $past({dist_hi, dist_lo});
    endproperty
    a_dist_ovr: assert property (p_dist_ovr) else $error("dist ovr");

    property p_dist_lo_wr;
        @(posedge clk) disable iff (!rst_b)
        reg_wr && reg_addr == ADDR_DIST_LO |=> dist_lo == $past(reg_wdata);
    endproperty
    a_dist_lo_wr: assert property (p_dist_lo_wr) else $error("dist lo");

    property p_status_rd;
        @(posedge clk) disable iff (!rst_b)
        reg_rd && reg_addr == ADDR_STATUS |=>
            reg_rvalid && reg_rdata == $past(status_live) && !reg_rdata[4];
    endproperty
    a_status_rd: assert property (p_status_rd) else $error("status");

    property p_fault_bit;
        @(posedge clk) disable iff (!rst_b)
        reg_rd && reg_addr == ADDR_STATUS && !fault_n |=> !reg_rdata[6];
    endproperty
    a_fault_bit: assert property (p_fault_bit) else $error("fault bit");

    property p_pll_bit;
        @(posedge clk) disable iff (!rst_b)
        reg_rd && reg_addr == ADDR_STATUS |=>
            reg_rdata[7] == $past(pll_unlocked_flag);
    endproperty
    a_pll_bit: assert property (p_pll_bit) else $error("pll bit");

    // checked against the pins, not against the design's own status word
    property p_flag_bits;
        @(posedge clk) disable iff (!rst_b)
        reg_rd && reg_addr == ADDR_STATUS |=>
            reg_rdata[5:0] == $past({undervoltage_flag_n, 1'b0,
                overcurrent_fault_n, overcurrent_warn_n,
                thermal_fault_n, thermal_warn_n});
    endproperty
    a_flag_bits: assert property (p_flag_bits) else $error("flags");

    property p_status_wr;
        @(posedge clk) disable iff (!rst_b)
        reg_wr && reg_addr == ADDR_STATUS |=>
            $stable({pwr_hi, pwr_lo, dist_hi, dist_lo, frd_hi, frd_lo});
    endproperty
    a_status_wr: assert property (p_status_wr) else $error("ro write");

    property p_frd_wr;
        @(posedge clk) disable iff (!rst_b)
        reg_wr && reg_addr == ADDR_FRD_LO |=> frd_lo == $past(reg_wdata);
    endproperty
    a_frd_wr: assert property (p_frd_wr) else $error("frd write");

    property p_frd_hi_wr;
        @(posedge clk) disable iff (!rst_b)
        reg_wr && reg_addr == ADDR_FRD_HI |=> frd_hi == $past(reg_wdata);
    endproperty
    a_frd_hi_wr: assert property (p_frd_hi_wr) else $error("frd hi");

    // the power stage may only come back once the fault has gone
    property p_hiz_rise;
        @(posedge clk) disable iff (!rst_b)
        $rose(bridge_hiz_ctrl) |-> $past(fault_n);
    endproperty
    a_hiz_rise: assert property (p_hiz_rise) else $error("hiz rise");
endmodule

// *** pcfs_host_model.sv ***
// host side of the byte register port of the correction/status slice
// assumes the bench clock; the bench calls wr and rd hierarchically
`timescale 1ns/1ps
module pcfs_host_model (
    // clock
    input wire logic clk,
    // register port
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // only this slice is reached, never the coefficient ram
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        // released data must not look valid, so show its inverse
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
    endtask
endmodule

// *** tb_power_correction_fault_status_regs.sv ***
// bench for pcfs_regs: reset values, overrides, status byte, fault timer
// assumes the host model drives the register port
`timescale 1ns/1ps
module tb_power_correction_fault_status_regs
    import pcfs_pkg::*;
;
    localparam int U = 4;
    // built-in coefficients, arbitrary but distinct from the reset zero
    localparam logic [15:0] DFLT_PWR = 16'h5a3c;
    localparam logic [15:0] DFLT_DIST = 16'h0f96;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic sel_m = 1'b0;
    logic sel_d = 1'b0;
    logic [7:0] flags = 8'hff;
    logic [7:0] addr, wdata, rdata, r, val [6];
    logic wr, rd, rvalid, hiz;
    logic [15:0] pwr_coef, dist_coef;
    logic [7:0] exp_q [$];
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;
    int i, n;
    logic [7:0] rv [6] = '{RST_PWR_HI, RST_PWR_LO, RST_DIST_HI, RST_DIST_LO,
                           RST_FRD_HI, RST_FRD_LO};
    always #4 clk = ~clk;
    pcfs_host_model host (.clk(clk), .reg_addr(addr), .reg_wr(wr),
        .reg_wdata(wdata), .reg_rd(rd));
    pcfs_regs #(.UNIT_CYC(U), .DEF_PWR(DFLT_PWR), .DEF_DIST(DFLT_DIST))
        DUT (.clk(clk), .rst_b(rst_b),
        .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd),
        .reg_rdata(rdata), .reg_rvalid(rvalid),
        .max_power_override_sel(sel_m), .distortion_override_sel(sel_d),
        .pll_unlocked_flag(flags[7]), .fault_n(flags[6]),
        .undervoltage_flag_n(flags[5]), .overcurrent_fault_n(flags[3]),
        .overcurrent_warn_n(flags[2]), .thermal_fault_n(flags[1]),
        .thermal_warn_n(flags[0]), .max_power_correction(pwr_coef),
        .distortion_comp_coef(dist_coef), .bridge_hiz_ctrl(hiz));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checked++;
        if (seen !== want) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic complete_run();
        $display("counts: checked=%0d failed=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask
    // oldest note is compared whenever read data is presented
    always @(posedge clk) begin
        if (rvalid === 1'b1) begin
            check(rdata, exp_q.pop_front());
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            complete_run();
        end
    end
    initial begin
        r = 8'd12;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        for (i = 0; i < 6; i++) begin
            rd_exp(ADDR_PWR_HI + 8'(i), rv[i]);
        end
        $display("test reset values done");
        // delays kept nonzero, zero is reserved
        // hold assertion needs at least 8 cycles low, so delay * U >= 8
        for (i = 2; i <= 3; i++) begin
            host.wr(ADDR_FRD_HI, 8'h00);
            host.wr(ADDR_FRD_LO, 8'(i));
            @(posedge clk);
            flags[6] <= 1'b0;
            @(posedge clk);
            #1 check(hiz, 1'b0);
            repeat (3) @(posedge clk);
            flags[6] <= 1'b1;
            n = 0;
            while (hiz !== 1'b1 && n < 100) begin
                @(posedge clk);
                n++;
            end
            check(n >= i * U && n <= i * U + 2, 1'b1);
        end
        $display("test fault recovery done");
        for (i = 0; i < 6; i++) begin
            r = lfsr(r);
            @(posedge clk);
            flags <= r;
            @(posedge clk);
            rd_exp(ADDR_STATUS, {r[7:5], 1'b0, r[3:0]});
        end
        flags <= 8'hff;
        $display("test status byte done");
        for (i = 0; i < 6; i++) begin
            r = lfsr(r);
            val[i] = r;
            host.wr(ADDR_PWR_HI + 8'(i), r);
        end
        host.wr(ADDR_STATUS, 8'h00);
        host.wr(8'h40, 8'h5a);
        for (i = 0; i < 6; i++) begin
            rd_exp(ADDR_PWR_HI + 8'(i), val[i]);
        end
        rd_exp(8'h40, 8'h00);
        rd_exp(ADDR_STATUS, 8'hef);
        sel_m <= 1'b1;
        sel_d <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check(pwr_coef, {val[0], val[1]});
        check(dist_coef, {val[2], val[3]});
        @(posedge clk);
        sel_m <= 1'b0;
        sel_d <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check(pwr_coef, DFLT_PWR);
        check(dist_coef, DFLT_DIST);
        repeat (4) @(posedge clk);
        $display("test overrides done");
        complete_run();
    end
endmodule
